// *** hw/pmc_map.svh ***
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH
// Register byte addresses on the bus.
`define PMC_ADDR_STATUS_CTRL 4'h0
`define PMC_ADDR_COUNT 4'h4
`define PMC_ADDR_MODULO 4'h8
// Field positions inside the status/control register.
`define PMC_BIT_FLAG 7
`define PMC_SRC_HI 6
`define PMC_SRC_LO 5
`define PMC_BIT_IRQ_EN 4
`define PMC_PS_HI 3
`define PMC_PS_LO 0
// Reset values.
`define PMC_RST_BYTE 8'h00
`define PMC_RST_DIV 18'h00000
// Bus answers.
`define PMC_RESP_OKAY 2'b00
`define PMC_RESP_SLVERR 2'b10
`endif

// *** hw/pmc_pkg.sv ***
`default_nettype none
package pmc_pkg;
  // Prescaler ratio, wide enough for the largest division of 200000.
  typedef logic [17:0] pmc_ratio_type;
  // Selected counting source.
  typedef enum logic [1:0] {
    PMC_SRC_SLOW,
    PMC_SRC_EXT,
    PMC_SRC_INT
  } pmc_src_type;
endpackage : pmc_pkg
`default_nettype wire

// *** hw/pmc_counter.sv ***
// Overview of operation
// RULE_01: Bit 7 flags counter reached modulo.
// RULE_02: Write one clears flag; zero ignored.
// RULE_03: Bits 6-5 pick slow, external, internal sources.
// RULE_04: Changed source write clears prescaler, counter.
// RULE_05: Enable bit 4 gates interrupt request.
// RULE_06: Prescaler code zero stops counting.
// RULE_07: Ratio table depends on source bit 0.
// RULE_08: Changed prescaler write clears prescaler, counter.
// RULE_09: Reset clears flag, source, enable, prescaler.
// RULE_10: Count register read-only, writes ignored.
// RULE_11: Reset, modulo write, changes clear counter.
// RULE_12: Match wraps count to zero, sets flag.
// RULE_13: Modulo zero flags every prescaler edge.
// RULE_14: Any modulo write clears prescaler, counter.
// RULE_15: Modulo resets to zero.
// RULE_16: No device pins, internal signals only.
// RULE_17: Software enables source before selecting it.
// RULE_18: Count once per prescaler period, flag on wrap.
// RULE_19: Debug halt suspends counting, resumes held.
// RULE_20: Request is flag AND enable, level.
// RULE_21: Source edges synchronised, one step each.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`include "pmc_map.svh"
`default_nettype none
module pmc_counter
  import pmc_pkg::*;
(
  input wire logic clk, // Bus clock, 50 MHz.
  input wire logic rst_b, // Synchronous reset, active low.
  input wire logic low_power_1khz_osc, // Asynchronous 1 kHz source.
  input wire logic external_ref_clock, // Asynchronous external source.
  input wire logic internal_ref_clock, // Asynchronous internal source.
  input wire logic debug_halt, // Active background debug, same domain.
  input wire logic [3:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [3:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output logic match_irq // Interrupt request, level.
);

  // ----------------------------------------------------------------
  // Prescaler ratio lookup
  // ----------------------------------------------------------------

  // Ratio for each code and source bit 0; zero means off.
  function automatic pmc_ratio_type ratio_of(input logic [3:0] ps, input logic hi);
    pmc_ratio_type r;
    r = 18'd0;
    if (!hi) begin
      case (ps)
        4'h1: r = 18'd8;
        4'h2: r = 18'd32;
        4'h3: r = 18'd64;
        4'h4: r = 18'd128;
        4'h5: r = 18'd256;
        4'h6: r = 18'd512;
        4'h7: r = 18'd1024;
        4'h8: r = 18'd1;
        4'h9: r = 18'd2;
        4'ha: r = 18'd4;
        4'hb: r = 18'd10;
        4'hc: r = 18'd16;
        4'hd: r = 18'd100;
        4'he: r = 18'd500;
        4'hf: r = 18'd1000;
      endcase
    end else begin
      case (ps)
        4'h1: r = 18'd1024;
        4'h2: r = 18'd2048;
        4'h3: r = 18'd4096;
        4'h4: r = 18'd8192;
        4'h5: r = 18'd16384;
        4'h6: r = 18'd32768;
        4'h7: r = 18'd65536;
        4'h8: r = 18'd1000;
        4'h9: r = 18'd2000;
        4'ha: r = 18'd5000;
        4'hb: r = 18'd10000;
        4'hc: r = 18'd20000;
        4'hd: r = 18'd50000;
        4'he: r = 18'd100000;
        4'hf: r = 18'd200000;
      endcase
    end
    return r; // RULE_07
  endfunction : ratio_of

  // ----------------------------------------------------------------
  // Source synchronisers and edge detect
  // ----------------------------------------------------------------

  logic [2:0] src_meta_ff, src_sync_ff, src_last_ff, src_raw;
  logic [1:0] source_select_ff;
  logic [3:0] prescaler_select_ff;
  logic match_flag_ff, match_irq_enable_ff;
  logic [7:0] count_ff, modulo_ff;
  pmc_ratio_type div_ff;
  logic src_rise, tick, clear_cnt;

  assign src_raw = {internal_ref_clock, external_ref_clock, low_power_1khz_osc}; // RULE_16

  // Each source gets its own two-stage synchroniser; the edge detector only
  // looks at the second stage and its delayed copy so metastability never reaches the counter.
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          src_meta_ff[g] <= 1'b0;
          src_sync_ff[g] <= 1'b0;
          src_last_ff[g] <= 1'b0;
        end else begin
          src_meta_ff[g] <= src_raw[g];
          src_sync_ff[g] <= src_meta_ff[g]; // RULE_21
          src_last_ff[g] <= src_sync_ff[g];
        end
      end
    end
  endgenerate

  // Source mux; codes 2 and 3 both pick the internal clock.
  always_comb begin
    unique case (source_select_ff)
      2'b00: src_rise = src_sync_ff[0] & ~src_last_ff[0]; // RULE_03
      2'b01: src_rise = src_sync_ff[1] & ~src_last_ff[1]; // RULE_03
      default: src_rise = src_sync_ff[2] & ~src_last_ff[2]; // RULE_03
    endcase
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------

  logic aw_held_ff;
  logic w_held_ff;
  logic [3:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic wstrb0_ff;
  logic wr_go;
  logic wr_ok;
  logic [7:0] wbyte;
  logic wr_sc;
  logic wr_mod;
  logic [31:0] rd_word;

  assign wr_go = aw_held_ff & w_held_ff & ~s_axi_bvalid;
  assign wr_ok = wr_go & wstrb0_ff;
  assign wbyte = wdata_ff[7:0];
  assign wr_sc = wr_ok & (awaddr_ff == `PMC_ADDR_STATUS_CTRL);
  assign wr_mod = wr_ok & (awaddr_ff == `PMC_ADDR_MODULO);

  // Address and data are caught independently, in either order.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      wdata_ff <= 32'h0000_0000;
      wstrb0_ff <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PMC_RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held_ff & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_held_ff & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= {s_axi_awaddr[3:2], 2'b00};
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb0_ff <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_ff == `PMC_ADDR_STATUS_CTRL || awaddr_ff == `PMC_ADDR_COUNT
                        || awaddr_ff == `PMC_ADDR_MODULO) ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
      end
    end
  end

  // Read mux; the count is live state, writes to it are dropped.
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case ({s_axi_araddr[3:2], 2'b00})
      `PMC_ADDR_STATUS_CTRL: rd_word[7:0] = {match_flag_ff, source_select_ff,
                                             match_irq_enable_ff, prescaler_select_ff};
      `PMC_ADDR_COUNT: rd_word[7:0] = count_ff; // RULE_10
      `PMC_ADDR_MODULO: rd_word[7:0] = modulo_ff;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PMC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= (s_axi_araddr[3:2] == 2'b11) ? `PMC_RESP_SLVERR : `PMC_RESP_OKAY;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------

  // Every modulo write, and status writes that change a selection, restart the timebase.
  assign clear_cnt = wr_mod // RULE_14
    | (wr_sc & (wbyte[`PMC_SRC_HI:`PMC_SRC_LO] != source_select_ff)) // RULE_04
    | (wr_sc & (wbyte[`PMC_PS_HI:`PMC_PS_LO] != prescaler_select_ff)); // RULE_08

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      source_select_ff <= 2'b00; // RULE_09
      match_irq_enable_ff <= 1'b0; // RULE_09
      prescaler_select_ff <= 4'h0; // RULE_09
      modulo_ff <= `PMC_RST_BYTE; // RULE_15
    end else begin
      if (wr_sc) begin
        source_select_ff <= wbyte[`PMC_SRC_HI:`PMC_SRC_LO];
        match_irq_enable_ff <= wbyte[`PMC_BIT_IRQ_EN];
        prescaler_select_ff <= wbyte[`PMC_PS_HI:`PMC_PS_LO];
      end
      if (wr_mod) begin
        modulo_ff <= wbyte;
      end
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and counter
  // ----------------------------------------------------------------

  pmc_ratio_type ratio;
  assign ratio = ratio_of(prescaler_select_ff, source_select_ff[0]);
  // A tick comes on the source edge that completes one ratio period.
  assign tick = src_rise & ~debug_halt & (ratio != 18'd0)
    & (div_ff == ratio - 18'd1); // RULE_06

  // Debug halt freezes both stages; the held values resume afterwards.
  always_ff @(posedge clk) begin
    if (!rst_b || clear_cnt) begin
      div_ff <= `PMC_RST_DIV; // RULE_11
      count_ff <= `PMC_RST_BYTE; // RULE_11
    end else if (src_rise && !debug_halt && ratio != 18'd0) begin // RULE_19
      div_ff <= tick ? `PMC_RST_DIV : div_ff + 18'd1; // RULE_18
      if (tick) begin
        count_ff <= (count_ff == modulo_ff) ? `PMC_RST_BYTE : count_ff + 8'd1; // RULE_12
      end
    end
  end

  // Set wins over a clear arriving in the same cycle.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      match_flag_ff <= 1'b0; // RULE_09
    end else if (tick && count_ff == modulo_ff) begin
      match_flag_ff <= 1'b1; // RULE_01 RULE_13
    end else if (wr_sc && wbyte[`PMC_BIT_FLAG]) begin
      match_flag_ff <= 1'b0; // RULE_02
    end
  end

  // Registered request; lags the flag by one cycle to stay glitch free.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      match_irq <= 1'b0;
    end else begin
      match_irq <= match_flag_ff & match_irq_enable_ff; // RULE_05 RULE_20
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  sequence wrap_s;
    tick && count_ff == modulo_ff;
  endsequence

  wrap_flag_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_12
    wrap_s |=> match_flag_ff && count_ff == 8'h00)
    else $error("Wrap did not zero count and set flag.");
  irq_follow_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_20
    match_irq == $past(match_flag_ff & match_irq_enable_ff))
    else $error("Request does not follow flag and enable.");
  flag_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_02
    match_flag_ff && !(wr_sc && wbyte[`PMC_BIT_FLAG]) |=> match_flag_ff)
    else $error("Flag dropped without a clearing write.");
  mod_clear_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_14
    wr_mod |=> count_ff == 8'h00 && div_ff == 18'd0)
    else $error("Modulo write did not clear counters.");
  off_still_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_06
    prescaler_select_ff == 4'h0 && !clear_cnt |=> $stable(count_ff))
    else $error("Counter moved with prescaler off.");
  halt_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_19
    debug_halt && !clear_cnt |=> $stable(count_ff) && $stable(div_ff))
    else $error("Counting during debug halt.");
  step_one_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_18
    tick && count_ff != modulo_ff && !clear_cnt |=> count_ff == $past(count_ff) + 8'd1)
    else $error("Counter did not step by one.");
  src_clear_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_04
    wr_sc && wbyte[`PMC_SRC_HI:`PMC_SRC_LO] != source_select_ff |=> count_ff == 8'h00)
    else $error("Source change did not clear count.");

endmodule : pmc_counter
`default_nettype wire

// *** tb/tb_top.sv ***
`include "pmc_map.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals and case table
  // ----------------------------------------
  localparam logic [3:0] a_sc = `PMC_ADDR_STATUS_CTRL;
  localparam logic [3:0] a_cnt = `PMC_ADDR_COUNT;
  localparam logic [3:0] a_mod = `PMC_ADDR_MODULO;
  localparam logic [1:0] ok = `PMC_RESP_OKAY;
  typedef struct packed {logic wr; logic [3:0] a; logic [31:0] d, e; logic [1:0] r;} pmc_row_type;
  logic clk = 1'b0, rst_b = 1'b0, debug_halt = 1'b0;
  logic osc_slow = 1'b0, clk_ext = 1'b0, clk_int = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, match_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] rd;
  int failures = 0, num_checks = 0;
  // Prescaler is off in these rows, so the count must stay at zero.
  pmc_row_type rows [11] = '{
    '{1'b0, a_sc, 32'h0, 32'h0, ok},
    '{1'b0, a_cnt, 32'h0, 32'h0, ok},
    '{1'b0, a_mod, 32'h0, 32'h0, ok},
    '{1'b1, a_mod, 32'h55, 32'h0, ok},
    '{1'b0, a_mod, 32'h0, 32'h55, ok},
    '{1'b1, a_cnt, 32'hff, 32'h0, ok},
    '{1'b0, a_cnt, 32'h0, 32'h0, ok},
    '{1'b1, a_sc, 32'hffff_ff70, 32'h0, ok},
    '{1'b0, a_sc, 32'h0, 32'h70, ok},
    '{1'b1, 4'hc, 32'h1, 32'h0, `PMC_RESP_SLVERR},
    '{1'b0, 4'hc, 32'h0, 32'h0, `PMC_RESP_SLVERR}};

  pmc_counter u_dut (.clk(clk), .rst_b(rst_b), .low_power_1khz_osc(osc_slow),
    .external_ref_clock(clk_ext), .internal_ref_clock(clk_int), .debug_halt(debug_halt),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .match_irq(match_irq));

  // Bus clock of 50 MHz.
  initial begin
    forever #10 clk = ~clk;
  end
  // Sources run all the time, so any selection finds its clock already going.
  initial begin
    forever #400 osc_slow = ~osc_slow;
  end
  initial begin
    forever #100 clk_ext = ~clk_ext;
  end
  initial begin
    forever #300 clk_int = ~clk_int;
  end
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // A leading edge keeps a handshake signal from being driven twice in one step.
  // Waits carry no limit of their own; only the watchdog ends a hung transfer.
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
  endtask : wr
  task automatic rdx(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(d, e);
  endtask : rdx
  // Waits for source edges, then lets the synchroniser settle before any read.
  task automatic edges(input int s, input int k);
    repeat (k) begin
      case (s)
        0: @(posedge osc_slow);
        1: @(posedge clk_ext);
        default: @(posedge clk_int);
      endcase
    end
    repeat (8) @(posedge clk);
  endtask : edges
  task automatic end_of_test();
    $display("Checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  // Watchdog sized well past the long external-source count.
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    end_of_test();
  end
  // Main sequence: table rows first, then counting cases.
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axi_wr(rows[i].a, rows[i].d, rsp);
      end else begin
        axi_rd(rows[i].a, rd, rsp);
        chk(rd, rows[i].e);
      end
      chk({30'h0, rsp}, {30'h0, rows[i].r});
    end
    // Writes are aligned just after a source edge so no edge is in flight.
    wr(a_sc, 32'h18);
    edges(0, 1);
    wr(a_mod, 32'h3);
    rdx(a_cnt, 32'h0);
    for (int k = 1; k <= 3; k++) begin
      edges(0, 1);
      rdx(a_cnt, 32'(k));
    end
    rdx(a_sc, 32'h18);
    edges(0, 1);
    rdx(a_cnt, 32'h0);
    rdx(a_sc, 32'h98);
    chk({31'h0, match_irq}, 32'h1);
    wr(a_sc, 32'h18);
    rdx(a_sc, 32'h98);
    wr(a_sc, 32'h98);
    rdx(a_sc, 32'h18);
    chk({31'h0, match_irq}, 32'h0);
    edges(0, 1);
    wr(a_mod, 32'h3);
    edges(0, 1);
    wr(a_sc, 32'h18);
    rdx(a_cnt, 32'h1);
    wr(a_sc, 32'h19);
    rdx(a_cnt, 32'h0);
    edges(0, 2);
    rdx(a_cnt, 32'h1);
    edges(2, 1);
    wr(a_sc, 32'h58);
    rdx(a_cnt, 32'h0);
    edges(2, 1);
    rdx(a_cnt, 32'h1);
    wr(a_mod, 32'h0);
    edges(2, 1);
    rdx(a_sc, 32'hd8);
    wr(a_sc, 32'hd8);
    rdx(a_sc, 32'h58);
    edges(2, 1);
    rdx(a_sc, 32'hd8);
    rdx(a_cnt, 32'h0);
    wr(a_mod, 32'h20);
    edges(2, 2);
    rdx(a_cnt, 32'h2);
    debug_halt <= 1'b1;
    edges(2, 3);
    rdx(a_cnt, 32'h2);
    debug_halt <= 1'b0;
    edges(2, 1);
    rdx(a_cnt, 32'h3);
    edges(1, 1);
    wr(a_sc, 32'h28);
    rdx(a_cnt, 32'h0);
    chk({31'h0, match_irq}, 32'h0);
    edges(1, 1000);
    rdx(a_cnt, 32'h1);
    rdx(a_sc, 32'ha8);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rdx(a_sc, 32'h0);
    rdx(a_mod, 32'h0);
    rdx(a_cnt, 32'h0);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
